//--- hw/mcrc_params.svh
// Constants for the machine check and run control block.
`ifndef MCRC_PARAMS_SVH
`define MCRC_PARAMS_SVH
// Register byte offsets.
`define MCRC_OFF_CONFIG   8'h00
`define MCRC_OFF_KEYS     8'h04
`define MCRC_OFF_STATUS   8'h08
`define MCRC_OFF_RUNSTATE 8'h0C
`define MCRC_OFF_STEPSEL  8'h10
// Configuration register fields and reset value.
`define MCRC_CFG_PRINT_HALT 0
`define MCRC_CFG_PUNCH_STOP 1
`define MCRC_CFG_RESET      2'h3
// Key register fields, each a one-shot press.
`define MCRC_KEY_SYS_RESET  0
`define MCRC_KEY_CHK_RESET  1
`define MCRC_KEY_RD_STOP    2
`define MCRC_KEY_RD_START   3
`define MCRC_KEY_EJECT      4
`define MCRC_KEY_PRESET     5
`define MCRC_KEY_PRG_STOP   6
`define MCRC_KEY_PRG_START  7
// Status register fields, one latched indicator each.
`define MCRC_ST_CARD_CMP    0
`define MCRC_ST_MISFEED     1
`define MCRC_ST_ODD_COUNT   2
`define MCRC_ST_DISK_VERIFY 3
`define MCRC_ST_TIMING      4
`define MCRC_ST_PRINT_SETUP 5
`define MCRC_ST_PUNCH_FEED  6
`define MCRC_ST_HOLE_COUNT  7
`define MCRC_ST_PUNCH_PAR   8
// Run state register fields.
`define MCRC_RS_RUN         0
`define MCRC_RS_RESET_IND   1
`define MCRC_RS_FINAL_CYC   2
`define MCRC_RS_RD_READY    3
`define MCRC_RS_RD_SELECT   4
`define MCRC_RS_INPUT_OK    5
`define MCRC_RS_PC_LSB      16
// Reader run-in card count and step hundreds reset digit.
`define MCRC_RUNIN_CARDS    3
`define MCRC_HUNDREDS_RESET 4'h0
`endif

//--- hw/mcrc_pkg.sv
// Types shared by the machine check and run control block.
`default_nettype none
package mcrc_pkg;
  // Disk write verification sequence.
  typedef enum logic [1:0] {
    MCRC_DV_IDLE   = 2'b00,
    MCRC_DV_REREAD = 2'b01,
    MCRC_DV_CMP    = 2'b10
  } mcrc_dv_state_t;
  // Bus response codes.
  typedef logic [1:0] mcrc_resp_t;
endpackage : mcrc_pkg
`default_nettype wire

//--- hw/mcrc_top.sv
// Machine check and run control with an AXI4-Lite register slave.
// Behaviour
// - Compare both card reads, stop on difference.
// - Refuse input track transfer on card error.
// - Release input track only on exact match; only bits [5:0] are compared, the check bit is not.
// - Reader misfeed lights indicator and halts.
// - Core transfers need odd bit count.
// - Parity-check address register, printer, punch chars.
// - Reread source, compare disk readback, stop.
// - Accumulator readout-reset to disk always errors.
// - Missing write enable plug errors every write.
// - Timing fault lights indicator and halts.
// - Printer setup needs odd of seven positions.
// - After setup error, finish line, print delta.
// - Punch feed fail, hopper, stacker set punch feed check.
// - Hole count error only when exit stops.
// - Parity-check every punch character.
// - System reset clears timing, sets indicators.
// - Reader stop drops ready; stop on transfer.
// - First run-in feeds three cards, start pulse.
// - Ejection only after reader stop, hopper empty.
// - Check reset clears parity, repeats instruction.
// - Step preset loads counter, does not execute.
// - Program stop at step end; start resumes.
// - Stored characters carry an odd check bit.
`default_nettype none
`include "mcrc_params.svh"
module mcrc_top
  import mcrc_pkg::*;
#(
  parameter int CHAR_W      = 7,
  parameter int RUNIN_CARDS = `MCRC_RUNIN_CARDS
) (
  // Clock and reset.
  input  wire  logic              CLK_SYS_I,
  input  wire  logic              RST_I,
  // AXI4-Lite write channels.
  input  wire  logic [7:0]        AWADDR_I,
  input  wire  logic              AWVALID_I,
  output var   logic              AWREADY_O,
  input  wire  logic [31:0]       WDATA_I,
  input  wire  logic [3:0]        WSTRB_I,
  input  wire  logic              WVALID_I,
  output var   logic              WREADY_O,
  output var   logic [1:0]        BRESP_O,
  output var   logic              BVALID_O,
  input  wire  logic              BREADY_I,
  // AXI4-Lite read channels.
  input  wire  logic [7:0]        ARADDR_I,
  input  wire  logic              ARVALID_I,
  output var   logic              ARREADY_O,
  output var   logic [31:0]       RDATA_O,
  output var   logic [1:0]        RRESP_O,
  output var   logic              RVALID_O,
  input  wire  logic              RREADY_I,
  // Card reader: paired characters of both readings.
  input  wire  logic              CARD_CMP_VALID_I,
  input  wire  logic [CHAR_W-1:0] CARD_FIRST_I,
  input  wire  logic [CHAR_W-1:0] CARD_SECOND_I,
  input  wire  logic              CARD_END_I,
  input  wire  logic              READER_MISFEED_I,
  input  wire  logic              FEED_HOPPER_EMPTY_I,
  input  wire  logic              INPUT_XFER_REQ_I,
  // Core, address register and output track characters.
  input  wire  logic              CORE_VALID_I,
  input  wire  logic [CHAR_W-1:0] CORE_CHAR_I,
  input  wire  logic              INSTR_VALID_I,
  input  wire  logic [CHAR_W-1:0] INSTR_CHAR_I,
  input  wire  logic              PRINT_VALID_I,
  input  wire  logic [CHAR_W-1:0] PRINT_CHAR_I,
  input  wire  logic              PUNCH_VALID_I,
  input  wire  logic [CHAR_W-1:0] PUNCH_CHAR_I,
  // Disk storage.
  input  wire  logic              DISK_WR_DONE_I,
  input  wire  logic              DISK_ACC_RESET_I,
  input  wire  logic              DISK_WE_PLUG_I,
  input  wire  logic              DISK_REREAD_DONE_I,
  input  wire  logic              DISK_CMP_VALID_I,
  input  wire  logic [CHAR_W-1:0] DISK_REC_CHAR_I,
  input  wire  logic [CHAR_W-1:0] DISK_CORE_CHAR_I,
  input  wire  logic              DISK_CMP_END_I,
  // Timing circuits.
  input  wire  logic              TIMING_FAULT_I,
  // Printer.
  input  wire  logic              SETUP_VALID_I,
  input  wire  logic [6:0]        SETUP_MAG_I,
  input  wire  logic              LINE_DONE_I,
  // Punch.
  input  wire  logic              PUNCH_FEED_FAIL_I,
  input  wire  logic              PUNCH_HOPPER_EMPTY_I,
  input  wire  logic              PUNCH_STACKER_FULL_I,
  input  wire  logic              PUNCH_HOLE_ERR_I,
  // Program sequencing.
  input  wire  logic              STEP_DONE_I,
  input  wire  logic [11:0]       NEXT_STEP_I,
  // Control outputs.
  output var   logic              RUN_O,
  output var   logic              INPUT_GRANT_O,
  output var   logic              READER_FEED_O,
  output var   logic              START_PULSE_O,
  output var   logic              EJECT_O,
  output var   logic              DISK_REREAD_O,
  output var   logic              DELTA_O,
  output var   logic              REPEAT_INSTR_O,
  output var   logic [11:0]       PC_O
);

  // Widths the logic is built for.
  if (CHAR_W != 7) $error("CHAR_W must be 7");
  if (RUNIN_CARDS < 1 || RUNIN_CARDS > 7) $error("RUNIN_CARDS out of range");

  function automatic logic odd_ok(input logic [CHAR_W-1:0] c);
    odd_ok = ^c;
  endfunction

  // Bus registers.
  logic        awready, wready, bvalid, arready, rvalid;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [7:0]  aw_addr, next_aw_addr;    // Latched write address.
  logic [31:0] w_data, next_w_data;      // Latched write data.
  logic [3:0]  w_strb, next_w_strb;      // Latched byte enables.
  mcrc_resp_t  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        wr_fire;                  // Write to the register map now.
  logic [7:0]  keys;                     // Key presses this cycle.

  // Control state.
  logic [1:0]  cfg, next_cfg;            // Halt options.
  logic [11:0] step_sel, next_step_sel;  // Step selector switches.
  logic [8:0]  err, next_err;            // Latched indicators.
  logic        run, next_run;
  logic        stop_req, next_stop_req;  // Program stop pending.
  logic        reset_ind, next_reset_ind;
  logic        final_cyc, next_final_cyc;
  logic        rd_select, next_rd_select;
  logic        rd_ready, next_rd_ready;
  logic        rd_stopped, next_rd_stopped;
  logic        first_run, next_first_run;  // Run-in not yet done.
  logic        card_bad, next_card_bad;    // Mismatch seen this card.
  logic        input_ok, next_input_ok;
  logic [2:0]  feed_cnt, next_feed_cnt;
  logic        start_wait, next_start_wait;
  logic        delta_pend, next_delta_pend;
  mcrc_dv_state_t dv, next_dv;
  logic        grant, next_grant, feed, next_feed, startp, next_startp;
  logic        eject, next_eject, reread, next_reread, delta, next_delta;
  logic        repeat_i, next_repeat_i;
  logic [11:0] pc, next_pc;
  logic        halting;                  // A stop-causing error is latched.

  // Bus handshakes and address decode.
  always_comb begin
    next_awready = awready;
    next_wready  = wready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    wr_fire      = 1'b0;
    // Address and data are taken in either order and held until both are here.
    if (AWVALID_I && awready) begin
      next_aw_addr = AWADDR_I;
      next_awready = 1'b0;
    end
    if (WVALID_I && wready) begin
      next_w_data = WDATA_I;
      next_w_strb = WSTRB_I;
      next_wready = 1'b0;
    end
    if (!awready && !wready && !bvalid) begin
      wr_fire     = 1'b1;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        `MCRC_OFF_CONFIG, `MCRC_OFF_KEYS, `MCRC_OFF_STEPSEL: next_bresp = 2'h0;
        default: next_bresp = 2'h2;
      endcase
    end
    if (bvalid && BREADY_I) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    // One read at a time; the answer comes the cycle after the address.
    if (ARVALID_I && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = 2'h0;
      unique case (ARADDR_I)
        `MCRC_OFF_CONFIG:   next_rdata = {30'h0, cfg};
        `MCRC_OFF_KEYS:     next_rdata = 32'h0;
        `MCRC_OFF_STATUS:   next_rdata = {23'h0, err};
        `MCRC_OFF_RUNSTATE: next_rdata = {4'h0, pc, 10'h0, input_ok, rd_select,
                                          rd_ready, final_cyc, reset_ind, run};
        `MCRC_OFF_STEPSEL:  next_rdata = {20'h0, step_sel};
        default: begin
          next_rdata = 32'h0;
          next_rresp = 2'h2;
        end
      endcase
    end
    if (rvalid && RREADY_I) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Key presses decode from a write to the key register, low byte lane only.
  assign keys = (wr_fire && aw_addr == `MCRC_OFF_KEYS && w_strb[0]) ? w_data[7:0] : 8'h00;

  // Bus registers.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
    end else begin
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Every latched indicator except printer setup stops the machine; that one
  // stops only when the halt option is set, and then only after the delta.
  // run interlock
  assign halting = |{err[8:6], err[4:0]} || (err[`MCRC_ST_PRINT_SETUP] && cfg[`MCRC_CFG_PRINT_HALT]
                   && !delta_pend);

  // Checks, indicators and run control.
  always_comb begin
    logic [8:0] set_e;
    logic [8:0] clr_e;
    set_e           = 9'h0;
    clr_e           = 9'h0;
    next_cfg        = cfg;
    next_step_sel   = step_sel;
    next_run        = run;
    next_stop_req   = stop_req;
    next_reset_ind  = reset_ind;
    next_final_cyc  = final_cyc;
    next_rd_select  = rd_select;
    next_rd_ready   = rd_ready;
    next_rd_stopped = rd_stopped;
    next_first_run  = first_run;
    next_card_bad   = card_bad;
    next_input_ok   = input_ok;
    next_feed_cnt   = feed_cnt;
    next_start_wait = start_wait;
    next_delta_pend = delta_pend;
    next_dv         = dv;
    next_pc         = pc;
    next_grant      = 1'b0;
    next_feed       = 1'b0;
    next_startp     = 1'b0;
    next_eject      = 1'b0;
    next_reread     = 1'b0;
    next_delta      = 1'b0;
    next_repeat_i   = 1'b0;
    // Configuration and selector switches from software.
    if (wr_fire && aw_addr == `MCRC_OFF_CONFIG && w_strb[0]) next_cfg = w_data[1:0];
    if (wr_fire && aw_addr == `MCRC_OFF_STEPSEL) begin
      if (w_strb[0]) next_step_sel[7:0] = w_data[7:0];
      if (w_strb[1]) next_step_sel[11:8] = w_data[11:8];
    end
    if (CARD_CMP_VALID_I && (CARD_FIRST_I[5:0] != CARD_SECOND_I[5:0])) begin
      set_e[`MCRC_ST_CARD_CMP] = 1'b1;
      next_card_bad            = 1'b1;
    end
    if (CARD_END_I) begin
      next_input_ok = !next_card_bad && !(CARD_CMP_VALID_I && CARD_FIRST_I[5:0] != CARD_SECOND_I[5:0]);
      next_card_bad = 1'b0;
      if (start_wait && next_input_ok) begin
        next_startp     = 1'b1;
        next_start_wait = 1'b0;
      end
    end
    if (READER_MISFEED_I) set_e[`MCRC_ST_MISFEED] = 1'b1;
    if (CORE_VALID_I && !odd_ok(CORE_CHAR_I)) set_e[`MCRC_ST_ODD_COUNT] = 1'b1;
    if (INSTR_VALID_I && !odd_ok(INSTR_CHAR_I)) set_e[`MCRC_ST_ODD_COUNT] = 1'b1;
    if ((PRINT_VALID_I && !odd_ok(PRINT_CHAR_I)) || (SETUP_VALID_I && !odd_ok(SETUP_MAG_I))) begin
      set_e[`MCRC_ST_PRINT_SETUP] = 1'b1;
      next_delta_pend             = 1'b1;
    end
    if (LINE_DONE_I && delta_pend) begin
      next_delta      = 1'b1;
      next_delta_pend = 1'b0;
    end
    if (PUNCH_FEED_FAIL_I || PUNCH_HOPPER_EMPTY_I || PUNCH_STACKER_FULL_I) set_e[`MCRC_ST_PUNCH_FEED] = 1'b1;
    if (PUNCH_HOLE_ERR_I && cfg[`MCRC_CFG_PUNCH_STOP]) set_e[`MCRC_ST_HOLE_COUNT] = 1'b1;
    if (PUNCH_VALID_I && !odd_ok(PUNCH_CHAR_I)) set_e[`MCRC_ST_PUNCH_PAR] = 1'b1;
    if (TIMING_FAULT_I) set_e[`MCRC_ST_TIMING] = 1'b1;
    // Disk verification sequence, one write at a time.
    unique case (dv)
      MCRC_DV_IDLE: begin
        if (DISK_WR_DONE_I) begin
          if (DISK_ACC_RESET_I || !DISK_WE_PLUG_I) set_e[`MCRC_ST_DISK_VERIFY] = 1'b1;
          else begin
            next_reread = 1'b1;
            next_dv     = MCRC_DV_REREAD;
          end
        end
      end
      MCRC_DV_REREAD: if (DISK_REREAD_DONE_I) next_dv = MCRC_DV_CMP;
      MCRC_DV_CMP: begin
        if (DISK_CMP_VALID_I && DISK_REC_CHAR_I != DISK_CORE_CHAR_I) set_e[`MCRC_ST_DISK_VERIFY] = 1'b1;
        if (DISK_CMP_END_I) next_dv = MCRC_DV_IDLE;
      end
      default: next_dv = MCRC_DV_IDLE;
    endcase
    if (INPUT_XFER_REQ_I && run) begin
      if (rd_ready && input_ok && !err[`MCRC_ST_CARD_CMP]) next_grant = 1'b1;
      else next_run = 1'b0;
    end
    if (keys[`MCRC_KEY_RD_STOP]) begin
      next_rd_ready   = 1'b0;
      next_rd_stopped = 1'b1;
      next_feed_cnt   = 3'h0;
    end
    if (keys[`MCRC_KEY_RD_START]) begin
      next_rd_ready   = 1'b1;
      next_rd_stopped = 1'b0;
      // Reader start is the operator's restart for reader errors.
      clr_e[`MCRC_ST_CARD_CMP] = 1'b1;
      clr_e[`MCRC_ST_MISFEED]  = 1'b1;
      if (first_run) begin
        next_feed_cnt   = 3'(RUNIN_CARDS);
        next_start_wait = 1'b1;
        next_first_run  = 1'b0;
      end else begin
        next_feed_cnt = 3'h1;
      end
    end else if (feed_cnt != 3'h0 && !READER_MISFEED_I) begin
      // One feed pulse per cycle until the count is used up.
      next_feed     = 1'b1;
      next_feed_cnt = feed_cnt - 3'h1;
    end
    if (keys[`MCRC_KEY_EJECT] && rd_stopped && FEED_HOPPER_EMPTY_I) next_eject = 1'b1;
    if (keys[`MCRC_KEY_CHK_RESET]) begin
      clr_e[`MCRC_ST_ODD_COUNT]   = 1'b1;
      clr_e[`MCRC_ST_DISK_VERIFY] = 1'b1;
      clr_e[`MCRC_ST_PRINT_SETUP] = 1'b1;
      clr_e[`MCRC_ST_PUNCH_FEED]  = 1'b1;
      clr_e[`MCRC_ST_HOLE_COUNT]  = 1'b1;
      clr_e[`MCRC_ST_PUNCH_PAR]   = 1'b1;
      next_repeat_i               = 1'b1;
    end
    if (keys[`MCRC_KEY_SYS_RESET]) begin
      clr_e[`MCRC_ST_TIMING] = 1'b1;
      next_reset_ind         = 1'b1;
      next_final_cyc         = 1'b1;
      next_rd_select         = 1'b1;
      next_pc[11:8]          = `MCRC_HUNDREDS_RESET;
      next_run               = 1'b0;
      next_stop_req          = 1'b0;
      next_first_run         = 1'b1;
    end
    // Program counter follows completed steps while running.
    if (run && STEP_DONE_I) begin
      next_pc = NEXT_STEP_I;
      if (stop_req) begin
        next_run      = 1'b0;
        next_stop_req = 1'b0;
      end
    end
    if (keys[`MCRC_KEY_PRG_STOP] && run) next_stop_req = 1'b1;
    if (keys[`MCRC_KEY_PRESET]) begin
      next_pc  = step_sel;
      next_run = 1'b0;
    end
    if (keys[`MCRC_KEY_PRG_START] && !halting && !keys[`MCRC_KEY_SYS_RESET]) begin
      next_run       = 1'b1;
      next_stop_req  = 1'b0;
      next_reset_ind = 1'b0;
      next_final_cyc = 1'b0;
    end
    next_err = (err & ~clr_e) | set_e;
    if (|set_e && !(set_e == (9'h1 << `MCRC_ST_PRINT_SETUP) && !cfg[`MCRC_CFG_PRINT_HALT])
        && set_e != (9'h1 << `MCRC_ST_PRINT_SETUP)) next_run = 1'b0;
    if (halting) next_run = 1'b0;
  end

  // Control registers; indicators follow a system reset pattern.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cfg        <= `MCRC_CFG_RESET;
      step_sel   <= 12'h000;
      err        <= 9'h000;
      run        <= 1'b0;
      stop_req   <= 1'b0;
      reset_ind  <= 1'b1;
      final_cyc  <= 1'b1;
      rd_select  <= 1'b1;
      rd_ready   <= 1'b0;
      rd_stopped <= 1'b0;
      first_run  <= 1'b1;
      card_bad   <= 1'b0;
      input_ok   <= 1'b0;
      feed_cnt   <= 3'h0;
      start_wait <= 1'b0;
      delta_pend <= 1'b0;
      dv         <= MCRC_DV_IDLE;
      grant      <= 1'b0;
      feed       <= 1'b0;
      startp     <= 1'b0;
      eject      <= 1'b0;
      reread     <= 1'b0;
      delta      <= 1'b0;
      repeat_i   <= 1'b0;
      pc         <= 12'h000;
    end else begin
      cfg        <= next_cfg;
      step_sel   <= next_step_sel;
      err        <= next_err;
      run        <= next_run;
      stop_req   <= next_stop_req;
      reset_ind  <= next_reset_ind;
      final_cyc  <= next_final_cyc;
      rd_select  <= next_rd_select;
      rd_ready   <= next_rd_ready;
      rd_stopped <= next_rd_stopped;
      first_run  <= next_first_run;
      card_bad   <= next_card_bad;
      input_ok   <= next_input_ok;
      feed_cnt   <= next_feed_cnt;
      start_wait <= next_start_wait;
      delta_pend <= next_delta_pend;
      dv         <= next_dv;
      grant      <= next_grant;
      feed       <= next_feed;
      startp     <= next_startp;
      eject      <= next_eject;
      reread     <= next_reread;
      delta      <= next_delta;
      repeat_i   <= next_repeat_i;
      pc         <= next_pc;
    end
  end

  // Outputs, all straight from flip-flops.
  assign AWREADY_O      = awready;
  assign WREADY_O       = wready;
  assign BVALID_O       = bvalid;
  assign BRESP_O        = bresp;
  assign ARREADY_O      = arready;
  assign RVALID_O       = rvalid;
  assign RDATA_O        = rdata;
  assign RRESP_O        = rresp;
  assign RUN_O          = run;
  assign INPUT_GRANT_O  = grant;
  assign READER_FEED_O  = feed;
  assign START_PULSE_O  = startp;
  assign EJECT_O        = eject;
  assign DISK_REREAD_O  = reread;
  assign DELTA_O        = delta;
  assign REPEAT_INSTR_O = repeat_i;
  assign PC_O           = pc;

endmodule : mcrc_top
`default_nettype wire

//--- tb/mcrc_properties.sv
// Checker for the machine check and run control block.
`default_nettype none
module mcrc_properties
  import mcrc_pkg::*;
#(parameter int CHAR_W = 7) (
  // Clock and reset.
  input wire logic              CLK_SYS_I,
  input wire logic              RST_I,
  // Bus answers.
  input wire logic              BVALID_O,
  input wire logic              BREADY_I,
  input wire logic              RVALID_O,
  input wire logic              RREADY_I,
  // Checked inputs.
  input wire logic              TIMING_FAULT_I,
  input wire logic              READER_MISFEED_I,
  input wire logic              CORE_VALID_I,
  input wire logic [CHAR_W-1:0] CORE_CHAR_I,
  input wire logic              DISK_WR_DONE_I,
  input wire logic              DISK_WE_PLUG_I,
  input wire logic              INPUT_XFER_REQ_I,
  // Run control.
  input wire logic              RUN_O,
  input wire logic              INPUT_GRANT_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // A latched stop keeps the machine halted, not just for one edge.
  sequence s_halted;
    !RUN_O [*2];
  endsequence
  chk_timing_halt: assert property (TIMING_FAULT_I |=> s_halted)
    else $error("run kept after timing fault");
  chk_misfeed_halt: assert property (READER_MISFEED_I |=> !RUN_O)
    else $error("run kept after misfeed");
  chk_parity_halt: assert property (CORE_VALID_I && !(^CORE_CHAR_I) |=> s_halted)
    else $error("run kept after even core char");
  chk_disk_plug: assert property (DISK_WR_DONE_I && !DISK_WE_PLUG_I |=> !RUN_O)
    else $error("run kept on unplugged write");
  chk_grant_cause: assert property (INPUT_GRANT_O |-> $past(INPUT_XFER_REQ_I) && $past(RUN_O))
    else $error("grant without running request");
  chk_req_answer: assert property (RUN_O && INPUT_XFER_REQ_I |=> INPUT_GRANT_O || !RUN_O)
    else $error("input request neither granted nor stopped");
  chk_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write answer dropped early");
  chk_r_hold: assert property (RVALID_O && !RREADY_I |=> $stable(RVALID_O))
    else $error("read answer dropped early");
endmodule // mcrc_properties
bind mcrc_top mcrc_properties #(.CHAR_W(CHAR_W)) i_mcrc_properties (.*);
`default_nettype wire

//--- tb/mcrc_reader_model.sv
// Card reader model: one card of paired readings per feed pulse or burst of feed pulses.
`default_nettype none
module mcrc_reader_model
  import mcrc_pkg::*;
(
  // Clock, reset and feed control.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       feed_i,
  input  wire logic       bad_i,
  // Paired readings.
  output var  logic       valid_o,
  output var  logic [6:0] first_o,
  output var  logic [6:0] second_o,
  output var  logic       end_o
);
  int         cnt;  // Card phase, 0 when idle.
  logic [5:0] d;    // Data pattern, moves every cycle.
  logic [6:0] ch;   // Coded character.
  // A new feed restarts the card, so a burst of feeds ends in one card.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      d <= 6'h15;
    end else begin
      d <= d + 6'h0B;
      cnt <= feed_i ? 1 : (cnt == 6 || cnt == 0) ? 0 : cnt + 1;
    end
  end
  assign ch = {~^d, d};
  assign valid_o = cnt >= 2 && cnt <= 5;
  assign end_o = cnt == 6;
  // Outside a card the lines show a moving inverse, never a held value.
  assign first_o = valid_o ? ch : ~ch;
  assign second_o = valid_o ? ch ^ {6'h00, bad_i} : ~ch;
endmodule // mcrc_reader_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the machine check and run control block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, bad;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, RUN_O, INPUT_GRANT_O;
  logic READER_FEED_O, START_PULSE_O, EJECT_O, DISK_REREAD_O, DELTA_O, REPEAT_INSTR_O;
  logic CARD_CMP_VALID_I, CARD_END_I;
  logic [7:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, v, seed;
  logic [1:0] BRESP_O, RRESP_O, r;
  logic [11:0] PC_O;
  logic [6:0] CARD_FIRST_I, CARD_SECOND_I, c;
  logic [13:0] ev;
  logic [3:0] cv;
  int fail_count, checks, nf, ns, ne, st, i, j, k;
  int eb[18] = '{1, 4, 6, 6, 6, 7, 3, 5, -1, -1, -1, -1, -1, -1, 2, 2, 5, 8};  // Status bit per stimulus.
  wire [3:0] WSTRB_I = 4'hF;
  wire READER_MISFEED_I = ev[0], TIMING_FAULT_I = ev[1], PUNCH_FEED_FAIL_I = ev[2], PUNCH_HOPPER_EMPTY_I = ev[3],
    PUNCH_STACKER_FULL_I = ev[4], PUNCH_HOLE_ERR_I = ev[5], DISK_WR_DONE_I = ev[6], SETUP_VALID_I = ev[7],
    LINE_DONE_I = ev[8], STEP_DONE_I = ev[9], FEED_HOPPER_EMPTY_I = ev[10], DISK_REREAD_DONE_I = ev[11],
    DISK_CMP_END_I = ev[12], INPUT_XFER_REQ_I = ev[13], CORE_VALID_I = cv[0], INSTR_VALID_I = cv[1],
    PRINT_VALID_I = cv[2], PUNCH_VALID_I = cv[3], DISK_WE_PLUG_I = 1'b0, DISK_ACC_RESET_I = 1'b0;
  wire DISK_CMP_VALID_I = 1'b0;
  wire [6:0] CORE_CHAR_I = c, INSTR_CHAR_I = c, PRINT_CHAR_I = c, PUNCH_CHAR_I = c, SETUP_MAG_I = c;
  wire [6:0] DISK_REC_CHAR_I = c, DISK_CORE_CHAR_I = c;
  wire [11:0] NEXT_STEP_I = {5'h00, c};
  mcrc_top i_mcrc_top (.*);
  mcrc_reader_model i_mcrc_reader_model (.clk_i(CLK_SYS_I), .rst_i(RST_I), .feed_i(READER_FEED_O), .bad_i(bad),
    .valid_o(CARD_CMP_VALID_I), .first_o(CARD_FIRST_I), .second_o(CARD_SECOND_I), .end_o(CARD_END_I));
  initial begin
    CLK_SYS_I = 1'b0;
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end
  // Pulse counters for feeds, start pulses and card ends.
  always @(posedge CLK_SYS_I) begin
    nf += READER_FEED_O;
    ns += START_PULSE_O;
    ne += CARD_END_I;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Each channel is dropped at the edge that takes it; the answer is taken with ready held high.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS_I);
    {AWADDR_I, WDATA_I, AWVALID_I, WVALID_I, BREADY_I} <= {a, d, 3'b111};
    do begin
      @(posedge CLK_SYS_I);
      if (AWREADY_O) AWVALID_I <= 1'b0;
      if (WREADY_O) WVALID_I <= 1'b0;
    end while (BVALID_O !== 1'b1);
    r = BRESP_O;
    BREADY_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK_SYS_I);
    {ARADDR_I, ARVALID_I, RREADY_I} <= {a, 2'b11};
    do begin
      @(posedge CLK_SYS_I);
      if (ARREADY_O) ARVALID_I <= 1'b0;
    end while (RVALID_O !== 1'b1);
    {v, r} = {RDATA_O, RRESP_O};
    RREADY_I <= 1'b0;
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge CLK_SYS_I) ev <= m;
    @(posedge CLK_SYS_I) ev <= '0;
  endtask
  task automatic close_out();
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLK_SYS_I);
    fail_count++;
    close_out();
  end
  initial begin
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, AWADDR_I, ARADDR_I, WDATA_I} = '0;
    {ev, cv, c, bad, RST_I, seed} = {26'h0, 1'b1, 32'h95B7};
    repeat (10) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    rd(8'h00);
    ck(v, 32'h3);
    rd(8'h0C);
    ck(v & 32'hF16, 32'h16);
    rd(8'h1C);
    ck(32'(r), 32'h2);
    wr(8'h08, 32'h1);
    ck(32'(r), 32'h2);
    wr(8'h04, 32'h8);
    for (i = 0; i < 200 && ns == 0; i++) @(posedge CLK_SYS_I);
    ck(nf * 16 + ns, 32'h31);
    wr(8'h04, 32'h80);
    pulse(14'h2000);
    @(posedge CLK_SYS_I) ck(32'(INPUT_GRANT_O), 1);
    // Every error source except the card and disk compares and the accumulator reset, and every parity path, then a clear and a restart.
    for (k = 0; k < 18; k++) begin
      if (st != 0) wr(8'h04, 32'h0B);
      wr(8'h04, 32'h80);
      ck(32'(RUN_O), 1);
      if (k < 14) pulse(14'(1 << k));
      else begin
        j = xs();
        @(posedge CLK_SYS_I) {c, cv} <= {~^j[5:0], j[5:0], 4'(1 << (k - 14))};
        @(posedge CLK_SYS_I) c <= {^j[5:0], j[5:0]};
        @(posedge CLK_SYS_I) cv <= '0;
      end
      if (eb[k] == 5) begin
        pulse(14'h100);
        for (i = 0; i < 20 && DELTA_O !== 1'b1; i++) @(posedge CLK_SYS_I);
        ck(32'(DELTA_O), 1);
        repeat (2) @(posedge CLK_SYS_I);
      end
      @(posedge CLK_SYS_I) ck(32'(RUN_O), 32'(eb[k] < 0));
      st = eb[k] < 0 ? 0 : 1 << eb[k];
      rd(8'h08);
      ck(v, st);
    end
    bad <= 1'b1;
    wr(8'h04, 32'h0B);
    ck(32'(REPEAT_INSTR_O), 1);
    j = ne;
    for (i = 0; i < 100 && ne == j; i++) @(posedge CLK_SYS_I);
    wr(8'h04, 32'h80);
    ck(32'(RUN_O), 0);
    pulse(14'h2000);
    @(posedge CLK_SYS_I) ck(32'(INPUT_GRANT_O), 0);
    rd(8'h08);
    ck(v, 32'h1);
    wr(8'h10, 32'h123);
    wr(8'h04, 32'h20);
    ck(32'(PC_O), 32'h123);
    close_out();
  end
endmodule // testbench
`default_nettype wire
